// ==== hdl/gdp_pkg.sv ====
// Package of constants for the general pin direction and polarity block
package gdp_pkg;
  // ----------------------------------------
  // Register map and widths
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] PIN_CFG_GROUP_B_OFS = 8'h09;
  localparam logic [7:0] PIN_CFG_GROUP_C_OFS = 8'h0a;
  localparam logic [7:0] PIN_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] PIN_OUT_OFS = 8'h0d;
  localparam logic [7:0] PIN_CFG_GROUP_B_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_GROUP_C_RST = 8'h00;
  localparam logic [7:0] PIN_OUT_RST = 8'h00;
  localparam logic [7:0] GROUP_C_MASK = 8'h3f;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ----------------------------------------
  // Pin layout
  // ----------------------------------------
  localparam int NUM_PINS = 7;
  localparam int NUM_B = 4;
  localparam int SYNC_STAGES = 2;
  typedef logic [NUM_PINS-1:0] gdp_pins_t;
endpackage

// ==== hdl/gdp_pin_sync.sv ====
// Two-stage synchroniser for the external pin levels
`timescale 1ns/1ps
module gdp_pin_sync #(
  parameter int WIDTH = 7
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage is read only by the second stage
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (clk_en)
    begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

// ==== hdl/gdp_top.sv ====
// Direction and polarity configuration for general pins four to ten
//
// Notes on behaviour
// - Group B register at 0x09, read-write, resets to all zeros.
// - Pin four: bit 0 direction, bit 1 polarity, in group B.
// - Pin five: bit 2 direction, bit 3 polarity, in group B.
// - Pin six: bit 4 direction, bit 5 polarity, in group B.
// - Pin seven: bit 6 direction, bit 7 polarity, in group B.
// - Pin eight: bit 0 direction, bit 1 polarity, in group C.
// - Pin nine: bit 2 direction, bit 3 polarity, in group C.
// - Pin ten: bit 4 direction, bit 5 polarity, in group C.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module gdp_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [gdp_pkg::ADDR_W-1:0] addr,
  input wire logic [gdp_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [gdp_pkg::DATA_W-1:0] rdata,
  input wire logic [gdp_pkg::NUM_PINS-1:0] pin_in,
  output logic [gdp_pkg::NUM_PINS-1:0] pin_out,
  output logic [gdp_pkg::NUM_PINS-1:0] pin_oe
);
  import gdp_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pin_cfg_group_b_r;
  logic [7:0] pin_cfg_group_c_r;
  gdp_pins_t pin_logic_out_r;
  logic [7:0] rdata_r;
  gdp_pins_t pin_out_r;
  gdp_pins_t pin_oe_r;
  gdp_pins_t pin_sync;

  // Direction and polarity bit pairs, pin four first
  wire logic [13:0] cfg_pairs = {pin_cfg_group_c_r[5:0], pin_cfg_group_b_r};
  gdp_pins_t dir_bits;
  gdp_pins_t pol_bits;

  // Split the pairs: even bit direction, odd bit polarity
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_split
    assign dir_bits[i] = cfg_pairs[2*i];
    assign pol_bits[i] = cfg_pairs[2*i+1];
  end

  // Apply sense: active low inverts, active high passes
  function automatic gdp_pins_t apply_sense(input gdp_pins_t v, input gdp_pins_t pol);
    apply_sense = v ^ ~pol;
  endfunction

  // ----------------------------------------
  // Decode and next values
  // ----------------------------------------
  wire logic hit_b = (addr == PIN_CFG_GROUP_B_OFS);
  wire logic hit_c = (addr == PIN_CFG_GROUP_C_OFS);
  wire logic hit_lvl = (addr == PIN_LEVEL_OFS);
  wire logic hit_out = (addr == PIN_OUT_OFS);
  wire gdp_pins_t logic_in = apply_sense(pin_sync, pol_bits);
  wire gdp_pins_t pin_out_nxt = apply_sense(pin_logic_out_r, pol_bits);
  wire logic [7:0] rdata_nxt = hit_b ? pin_cfg_group_b_r :
                               hit_c ? pin_cfg_group_c_r :
                               hit_lvl ? {1'b0, logic_in} :
                               hit_out ? {1'b0, pin_logic_out_r} : RD_UNMAPPED;

  gdp_pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .d_in(pin_in),
    .q_out(pin_sync)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_cfg_group_b_r <= PIN_CFG_GROUP_B_RST;
      pin_cfg_group_c_r <= PIN_CFG_GROUP_C_RST;
      pin_logic_out_r <= PIN_OUT_RST[NUM_PINS-1:0];
    end
    else if (clk_en && wr_stb)
    begin
      if (hit_b)
        pin_cfg_group_b_r <= wdata;
      if (hit_c)
        pin_cfg_group_c_r <= wdata & GROUP_C_MASK;
      if (hit_out)
        pin_logic_out_r <= wdata[NUM_PINS-1:0];
    end
  end

  // Read data and registered pin drive
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= RD_UNMAPPED;
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end
    else if (clk_en)
    begin
      rdata_r <= rd_stb ? rdata_nxt : RD_UNMAPPED;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= dir_bits;
    end
  end

  assign rdata = rdata_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_wr_b;
    clk_en && wr_stb && hit_b;
  endsequence

  sequence s_rd_b;
    clk_en && rd_stb && hit_b;
  endsequence

  sequence s_wr_c;
    clk_en && wr_stb && hit_c;
  endsequence

  sequence s_rd_c;
    clk_en && rd_stb && hit_c;
  endsequence

  property p_reset_zero;
    @(posedge sys_clk) $fell(rst) |-> (pin_cfg_group_b_r == 8'h00 && pin_oe == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("group B not zero after reset");

  property p_wr_rd_b;
    @(posedge sys_clk) disable iff (rst)
      s_wr_b ##1 s_rd_b |-> ##1 (rdata == $past(wdata, 2));
  endproperty
  a_wr_rd_b: assert property (p_wr_rd_b) else $error("group B readback wrong");

  property p_wr_rd_c;
    @(posedge sys_clk) disable iff (rst)
      s_wr_c ##1 s_rd_c |-> ##1 (rdata == ($past(wdata, 2) & GROUP_C_MASK));
  endproperty
  a_wr_rd_c: assert property (p_wr_rd_c) else $error("group C readback wrong");

  property p_dir4;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[0] == $past(pin_cfg_group_b_r[0]);
  endproperty
  a_dir4: assert property (p_dir4) else $error("pin four direction wrong");

  property p_dir5;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[1] == $past(pin_cfg_group_b_r[2]);
  endproperty
  a_dir5: assert property (p_dir5) else $error("pin five direction wrong");

  property p_dir6;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[2] == $past(pin_cfg_group_b_r[4]);
  endproperty
  a_dir6: assert property (p_dir6) else $error("pin six direction wrong");

  property p_dir7;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[3] == $past(pin_cfg_group_b_r[6]);
  endproperty
  a_dir7: assert property (p_dir7) else $error("pin seven direction wrong");

  property p_pol7;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[3] == ($past(pin_logic_out_r[3]) ^ ~$past(pin_cfg_group_b_r[7]));
  endproperty
  a_pol7: assert property (p_pol7) else $error("pin seven polarity wrong");

  // Sampled reset in the antecedent skips the edge on which the drive is still held at zero
  property p_pol4;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[0] == ($past(pin_logic_out_r[0]) ^ ~$past(pin_cfg_group_b_r[1]));
  endproperty
  a_pol4: assert property (p_pol4) else $error("pin four polarity wrong");

  property p_pol5;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[1] == ($past(pin_logic_out_r[1]) ^ ~$past(pin_cfg_group_b_r[3]));
  endproperty
  a_pol5: assert property (p_pol5) else $error("pin five polarity wrong");

  property p_pol6;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[2] == ($past(pin_logic_out_r[2]) ^ ~$past(pin_cfg_group_b_r[5]));
  endproperty
  a_pol6: assert property (p_pol6) else $error("pin six polarity wrong");

  property p_dir8;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[4] == $past(pin_cfg_group_c_r[0]);
  endproperty
  a_dir8: assert property (p_dir8) else $error("pin eight direction wrong");

  property p_dir9;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[5] == $past(pin_cfg_group_c_r[2]);
  endproperty
  a_dir9: assert property (p_dir9) else $error("pin nine direction wrong");

  property p_dir10;
    @(posedge sys_clk) disable iff (rst) clk_en |=> pin_oe[6] == $past(pin_cfg_group_c_r[4]);
  endproperty
  a_dir10: assert property (p_dir10) else $error("pin ten direction wrong");

  property p_pol8;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[4] == ($past(pin_logic_out_r[4]) ^ ~$past(pin_cfg_group_c_r[1]));
  endproperty
  a_pol8: assert property (p_pol8) else $error("pin eight polarity wrong");

  property p_pol9;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[5] == ($past(pin_logic_out_r[5]) ^ ~$past(pin_cfg_group_c_r[3]));
  endproperty
  a_pol9: assert property (p_pol9) else $error("pin nine polarity wrong");

  property p_pol10;
    @(posedge sys_clk) disable iff (rst)
      clk_en && !rst |=> pin_out[6] == ($past(pin_logic_out_r[6]) ^ ~$past(pin_cfg_group_c_r[5]));
  endproperty
  a_pol10: assert property (p_pol10) else $error("pin ten polarity wrong");

  property p_in_sense;
    @(posedge sys_clk) disable iff (rst)
      clk_en && rd_stb && hit_lvl |=> rdata[6:0] == $past(pin_sync ^ ~pol_bits);
  endproperty
  a_in_sense: assert property (p_in_sense) else $error("sampled level sense wrong");
endmodule

// ==== tb/gdp_board_model.sv ====
// Board model for the seven general pins
`timescale 1ns/1ps
module gdp_board_model (
  input wire logic [gdp_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [gdp_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [gdp_pkg::NUM_PINS-1:0] ext_lvl,
  output logic [gdp_pkg::NUM_PINS-1:0] pin_in
);
  import gdp_pkg::*;
  // Wire level: the block where it drives, else the board
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

// ==== tb/tb_gdp_top.sv ====
// Self-checking bench for the pin direction and polarity block
`timescale 1ns/1ps
module tb_gdp_top;
  import gdp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata, cb, cc, ov;
  gdp_pins_t pin_in, pin_out, pin_oe, dir, pol;
  gdp_pins_t ext_lvl = '0;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int n_checks = 0;
  // Clock
  always #10 sys_clk = ~sys_clk;
  gdp_top gdp_top_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  gdp_board_model gdp_board_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task test_done;
    if (exp_q.size() != 0)
      n_errors++;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Direction (o=0) or polarity (o=1) bit of each pin
  function automatic gdp_pins_t fld(input logic [7:0] b, input logic [7:0] c, input int o);
    gdp_pins_t r;
    for (int k = 0; k < NUM_PINS; k++)
      r[k] = (k < NUM_B) ? b[2*k+o] : c[2*(k-NUM_B)+o];
    return r;
  endfunction
  // Read data monitor: oldest note against the cycle after each read
  always @(posedge sys_clk)
  begin
    if (rd_d)
    begin
      if (exp_q.size() > 0)
        chk(rdata, exp_q.pop_front());
      else
        n_errors++;
    end
    rd_d <= rd_stb & clk_en & ~rst;
  end
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    test_done;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h8e1e));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({1'b0, pin_oe}, 8'h00);
    rd(PIN_CFG_GROUP_B_OFS, PIN_CFG_GROUP_B_RST);
    rd(PIN_CFG_GROUP_C_OFS, PIN_CFG_GROUP_C_RST);
    rd(8'h3f, RD_UNMAPPED);
    chk({1'b0, pin_out}, 8'h7f);
    for (int i = 0; i < 12; i++)
    begin
      cb = 8'($urandom);
      cc = 8'($urandom);
      ov = 8'($urandom);
      ext_lvl <= gdp_pins_t'($urandom);
      wr(PIN_CFG_GROUP_B_OFS, cb);
      rd(PIN_CFG_GROUP_B_OFS, cb);
      wr(PIN_CFG_GROUP_C_OFS, cc);
      rd(PIN_CFG_GROUP_C_OFS, cc & GROUP_C_MASK);
      wr(PIN_OUT_OFS, ov);
      rd(PIN_OUT_OFS, {1'b0, ov[6:0]});
      idle(4);
      dir = fld(cb, cc, 0);
      pol = fld(cb, cc, 1);
      chk({1'b0, pin_oe}, {1'b0, dir});
      chk({1'b0, pin_out}, {1'b0, ov[6:0] ^ ~pol});
      rd(PIN_LEVEL_OFS, {1'b0, (ov[6:0] & dir) | ((ext_lvl ^ ~pol) & ~dir)});
    end
    // Clock enable low freezes the configuration and the pin drive
    clk_en <= 1'b0;
    wr(PIN_CFG_GROUP_B_OFS, ~cb);
    idle(2);
    chk({1'b0, pin_oe}, {1'b0, dir});
    clk_en <= 1'b1;
    rd(PIN_CFG_GROUP_B_OFS, cb);
    // Reset in mid-run clears the configuration again
    idle(2);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({1'b0, pin_oe}, 8'h00);
    rd(PIN_CFG_GROUP_B_OFS, PIN_CFG_GROUP_B_RST);
    rd(PIN_CFG_GROUP_C_OFS, PIN_CFG_GROUP_C_RST);
    rd(PIN_OUT_OFS, PIN_OUT_RST);
    idle(3);
    test_done;
  end
endmodule
